// *** logic/bqs_defines.vh ***
// Purpose: shared constants for the burst-of-four ddr sram port model
// Assumes: included by bare name from logic/ files
// Notes:   timing counts derive from times and the 100 ns system clock
`ifndef BQS_DEFINES_VH
`define BQS_DEFINES_VH
// ----------------------------------------------------------------
// widths and burst
// ----------------------------------------------------------------
`define BQS_BURST_LEN      4
`define BQS_BEAT_W         2
`define BQS_BEAT_LAST      2'h3
`define BQS_BEAT_ZERO      2'h0
`define BQS_BEAT_ONE       2'h1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BQS_SYS_PERIOD_NS  100
`define BQS_LOCK_CYCLES    2048
`define BQS_DOFF_MIN_NS    5
`define BQS_KSTATIC_NS     30
// least times round up, never under one cycle
`define BQS_DOFF_CYC  (((`BQS_DOFF_MIN_NS + `BQS_SYS_PERIOD_NS - 1) / `BQS_SYS_PERIOD_NS) < 1 ? 1 : ((`BQS_DOFF_MIN_NS + `BQS_SYS_PERIOD_NS - 1) / `BQS_SYS_PERIOD_NS))
`define BQS_KSTAT_CYC (((`BQS_KSTATIC_NS + `BQS_SYS_PERIOD_NS - 1) / `BQS_SYS_PERIOD_NS) < 1 ? 1 : ((`BQS_KSTATIC_NS + `BQS_SYS_PERIOD_NS - 1) / `BQS_SYS_PERIOD_NS))
`endif

// *** logic/bqs_sync2.v ***
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module bqs_sync2 #(
  parameter W = 1                      // bits to synchronise
) (
  input  wire         sys_clk,         // system clock
  input  wire         rst_n,           // async reset, active low
  input  wire [W-1:0] async_in,        // raw pin levels
  output reg  [W-1:0] sync_out         // synchronised levels
);
  reg [W-1:0] meta_q;                  // first stage, metastability catch

  // ----------------------------------------------------------------
  // two stage capture
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // bqs_sync2

// *** logic/bqs_port.v ***
// Purpose: burst-of-four ddr sram port: commands, burst, masks, forwarding, lock
// Assumes: k/k_n/pins are slow vs sys_clk (800 ns link period) and are sampled
// Notes:   reads return beats on successive k/k_n rising edges once issued
//
// Behaviour
// - burst counter makes four beat addresses
// - outputs disabled one cycle after idle
// - each write beat has its own mask
// - static clock resets loop, relock needed
// - read after same-address write is forwarded
`timescale 1ns/10ps
`include "bqs_defines.vh"
module bqs_port #(
  parameter AW        = 4,             // burst base address width
  parameter DW        = 18,            // data width per beat
  parameter BW        = 2,             // byte lanes per beat
  parameter LOCK_CYC  = `BQS_LOCK_CYCLES, // k rises needed for lock
  parameter KSTAT_CYC = `BQS_KSTAT_CYC  // static sys cycles that reset the loop
) (
  input  wire          sys_clk,        // system clock, 10 MHz
  input  wire          rst_n,          // async reset, active low
  input  wire          k_clk,          // input clock true
  input  wire          k_clk_n,        // input clock complement
  input  wire          rd_sel_n,       // read select, active low
  input  wire          wr_sel_n,       // write select, active low
  input  wire [AW-1:0] addr,           // burst base address
  input  wire [BW-1:0] byte_write_mask_n, // per-beat byte write mask, low writes
  input  wire [DW-1:0] wr_data,        // write data beat
  input  wire          dll_off_n,      // loop disable, low resets loop
  output reg  [DW-1:0] rd_data,        // read data beat
  output reg           rd_data_oe,     // read data output enable
  output reg           echo_clock_true,// echo clock true
  output reg           echo_clock_comp,// echo clock complement
  output reg           output_valid_flag, // read beat valid
  output reg           dll_locked      // loop locked status
);
  localparam LANE   = DW / BW;         // bits per byte lane
  localparam DEPTH  = 1 << (AW + `BQS_BEAT_W); // word count
  localparam CW     = 12;              // lock counter width
  localparam ST_IDLE = 1'b0;           // no burst running
  localparam ST_BURST = 1'b1;          // beats in flight

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire k_s, kn_s, rd_s_n, wr_s_n, doff_s_n;
  wire [AW-1:0] addr_s;
  wire [BW-1:0] mask_s;
  wire [DW-1:0] wd_s;
  bqs_sync2 #(.W(5+AW+BW+DW)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({k_clk, k_clk_n, rd_sel_n, wr_sel_n, dll_off_n, addr,
                byte_write_mask_n, wr_data}),
    .sync_out ({k_s, kn_s, rd_s_n, wr_s_n, doff_s_n, addr_s, mask_s, wd_s})
  );
  reg k_d1_q, kn_d1_q;                 // previous clock levels
  wire k_rise  = k_s & ~k_d1_q;        // rising edge of true clock
  wire kn_rise = kn_s & ~kn_d1_q;      // rising edge of complement

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  reg [DW-1:0] mem [0:DEPTH-1];        // array, declared locally
  reg          wst_q;                  // write burst state
  reg [1:0]    wbeat_q;                // write beat counter
  reg [AW-1:0] waddr_q;                // write burst base
  reg          wpend_q;                // write command awaiting data
  reg          rst_q;                  // read burst state
  reg [1:0]    rbeat_q;                // read beat counter
  reg [AW-1:0] raddr_q;                // read burst base
  reg          rfwd_q;                 // read served from forward buffer
  reg [DW-1:0] fwd_q [0:`BQS_BURST_LEN-1]; // last write's beats
  reg [AW-1:0] fwd_addr_q;             // last write's base
  reg          fwd_vld_q;              // forward buffer holds a write
  reg          idle_seen_q;            // previous k rise was idle_cycle
  reg [CW-1:0] lock_cnt_q;             // k rises since loop reset
  reg [7:0]    doff_cnt_q;             // cycles disable input low
  reg [7:0]    kstat_cnt_q;            // cycles since last k change
  reg          k_prev_any_q;           // k level for static detect
  wire [AW+`BQS_BEAT_W-1:0] wptr = {waddr_q, wbeat_q}; // write beat address
  wire [AW+`BQS_BEAT_W-1:0] rptr = {raddr_q, rbeat_q}; // read beat address
  // address of the beat being written now, first beat or later ones
  wire [AW+`BQS_BEAT_W-1:0] wcur = (wst_q == ST_IDLE) ? {waddr_q, `BQS_BEAT_ZERO} : wptr;
  wire beat_edge = k_rise | kn_rise;   // any beat edge
  wire cmd_idle  = rd_s_n & wr_s_n;    // idle_cycle on k rise
  wire loop_rst  = (doff_cnt_q >= `BQS_DOFF_CYC) | (kstat_cnt_q >= KSTAT_CYC);

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_d1_q  <= 1'b0;
      kn_d1_q <= 1'b0;
    end else begin
      k_d1_q  <= k_s;
      kn_d1_q <= kn_s;
    end
  end

  // ----------------------------------------------------------------
  // loop reset and lock; counters saturate to stay small
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      doff_cnt_q   <= 8'h00;
      kstat_cnt_q  <= 8'h00;
      k_prev_any_q <= 1'b0;
      lock_cnt_q   <= {CW{1'b0}};
      dll_locked   <= 1'b0;
    end else begin
      k_prev_any_q <= k_s;
      if (doff_s_n) doff_cnt_q <= 8'h00;
      else if (doff_cnt_q != 8'hFF) doff_cnt_q <= doff_cnt_q + 8'h01;
      if (k_s != k_prev_any_q) kstat_cnt_q <= 8'h00;
      else if (kstat_cnt_q != 8'hFF) kstat_cnt_q <= kstat_cnt_q + 8'h01;
      if (loop_rst) begin
        lock_cnt_q <= {CW{1'b0}};
        dll_locked <= 1'b0;
      end else if (k_rise && !dll_locked) begin
        if (lock_cnt_q == LOCK_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) dll_locked <= 1'b1;
        lock_cnt_q <= lock_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // write path: command on k, beats on alternate k/k_n rises
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q      <= ST_IDLE;
      wbeat_q    <= `BQS_BEAT_ZERO;
      waddr_q    <= {AW{1'b0}};
      wpend_q    <= 1'b0;
      fwd_addr_q <= {AW{1'b0}};
      fwd_vld_q  <= 1'b0;
    end else begin
      case (wst_q)
        ST_IDLE: begin
          if (k_rise && wpend_q) begin // first beat one cycle after command
            wst_q   <= ST_BURST;
            wbeat_q <= `BQS_BEAT_ONE;
            wpend_q <= 1'b0;
          end
          if (k_rise && !wr_s_n) begin
            wpend_q    <= 1'b1;
            waddr_q    <= addr_s;
            fwd_addr_q <= addr_s;
            fwd_vld_q  <= 1'b1;
          end
        end
        ST_BURST: begin
          if (beat_edge) begin
            wbeat_q <= wbeat_q + `BQS_BEAT_ONE;
            if (wbeat_q == `BQS_BEAT_LAST) wst_q <= ST_IDLE;
          end
        end
        default: wst_q <= ST_IDLE;
      endcase
    end
  end

  // beat data into array and forward buffer, per lane
  // masked lanes forward the old word so a forwarded read matches the array
  integer i;
  always @(posedge sys_clk) begin
    if ((wst_q == ST_IDLE && k_rise && wpend_q) || (wst_q == ST_BURST && beat_edge)) begin
      for (i = 0; i < BW; i = i + 1) begin
        if (!mask_s[i]) begin
          mem[wcur][i*LANE +: LANE] <= wd_s[i*LANE +: LANE];
        end
        fwd_q[wcur[`BQS_BEAT_W-1:0]][i*LANE +: LANE] <= mask_s[i] ?
          mem[wcur][i*LANE +: LANE] : wd_s[i*LANE +: LANE];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path and output drive
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q             <= ST_IDLE;
      rbeat_q           <= `BQS_BEAT_ZERO;
      raddr_q           <= {AW{1'b0}};
      rfwd_q            <= 1'b0;
      idle_seen_q       <= 1'b0;
      rd_data           <= {DW{1'b0}};
      rd_data_oe        <= 1'b0;
      echo_clock_true   <= 1'b0;
      echo_clock_comp   <= 1'b1;
      output_valid_flag <= 1'b0;
    end else begin
      echo_clock_true <= k_s;          // echoes follow input clocks
      echo_clock_comp <= kn_s;
      if (k_rise) idle_seen_q <= cmd_idle;
      case (rst_q)
        ST_IDLE: begin
          output_valid_flag <= 1'b0;
          if (k_rise && idle_seen_q) rd_data_oe <= 1'b0;
          if (k_rise && !rd_s_n) begin
            rst_q   <= ST_BURST;
            rbeat_q <= `BQS_BEAT_ZERO;
            raddr_q <= addr_s;
            rfwd_q  <= fwd_vld_q && (fwd_addr_q == addr_s);
          end
        end
        ST_BURST: begin
          if (beat_edge) begin
            rd_data <= rfwd_q ? fwd_q[rbeat_q] : mem[rptr];
            rd_data_oe        <= 1'b1;
            output_valid_flag <= 1'b1;
            rbeat_q <= rbeat_q + `BQS_BEAT_ONE;
            if (rbeat_q == `BQS_BEAT_LAST) rst_q <= ST_IDLE;
          end
        end
        default: rst_q <= ST_IDLE;
      endcase
    end
  end
endmodule // bqs_port

// *** tb/bqs_port_chk.sv ***
// Purpose: port checker for bqs_port
// Assumes: pins pass a two-flop synchroniser before use
// Notes:   windows allow for synchroniser and edge-detect delay
`timescale 1ns/10ps
module bqs_port_chk (
  input logic sys_clk,           // system clock
  input logic rst_n,             // async reset, active low
  input logic k_clk,             // input clock true
  input logic k_clk_n,           // input clock complement
  input logic rd_sel_n,          // read select, active low
  input logic dll_off_n,         // loop disable, active low
  input logic rd_data_oe,        // read data enable
  input logic echo_clock_true,   // echo clock true
  input logic echo_clock_comp,   // echo clock complement
  input logic output_valid_flag, // read beat valid
  input logic dll_locked         // loop lock status
);
  // ----------------------------------------------------------------
  // helper: cycles since read select was last low, saturating
  // ----------------------------------------------------------------
  logic [5:0] rd_age_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rd_age_q <= 6'h3F;
    else if (!rd_sel_n) rd_age_q <= 6'h00;
    else if (rd_age_q != 6'h3F) rd_age_q <= rd_age_q + 6'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // multi-step sequences
  // ----------------------------------------------------------------
  sequence doff_held; !dll_off_n [*5]; endsequence
  sequence k_still; $stable(k_clk) [*8]; endsequence
  echo_true_a: assert property ($rose(k_clk) |-> ##[1:4] echo_clock_true) else $error("echo true late");
  echo_comp_a: assert property ($rose(k_clk_n) |-> ##[1:4] echo_clock_comp) else $error("echo comp late");
  valid_oe_a: assert property (output_valid_flag |-> rd_data_oe) else $error("valid while off");
  oe_cause_a: assert property ($rose(rd_data_oe) |-> rd_age_q < 6'h20) else $error("oe without read");
  oe_idle_a: assert property (rd_age_q == 6'h3F |-> !rd_data_oe) else $error("oe stuck on");
  doff_reset_a: assert property (doff_held |=> !dll_locked) else $error("lock kept in doff");
  kstop_reset_a: assert property (k_still |-> ##4 !dll_locked) else $error("lock kept k static");
  lock_rise_a: assert property ($rose(dll_locked) |-> $past(dll_off_n, 4)) else $error("early lock");
endmodule // bqs_port_chk
bind bqs_port bqs_port_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .k_clk(k_clk),
  .k_clk_n(k_clk_n), .rd_sel_n(rd_sel_n), .dll_off_n(dll_off_n), .rd_data_oe(rd_data_oe),
  .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
  .output_valid_flag(output_valid_flag), .dll_locked(dll_locked));

// *** tb/bqs_ctl_model.sv ***
// Purpose: memory controller model driving k, commands and beats
// Assumes: 800 ns k period made from the 100 ns sys_clk
// Notes:   k stands still between calls; released data is inverted
`timescale 1ns/10ps
module bqs_ctl_model (
  input  logic        sys_clk,           // system clock
  output logic        k_clk,             // input clock true
  output logic        k_clk_n,           // input clock complement
  output logic        rd_sel_n,          // read select
  output logic        wr_sel_n,          // write select
  output logic [3:0]  addr,              // burst base
  output logic [1:0]  byte_write_mask_n, // beat mask
  output logic [17:0] wr_data            // beat data
);
  initial begin
    {k_clk, k_clk_n, rd_sel_n, wr_sel_n} = 4'h7;
    addr = 4'h0;
    byte_write_mask_n = 2'h3;
    wr_data = 18'h00000;
  end
  // pins set mid half period, held across the next k edge
  task automatic step(input logic r, input logic w, input logic [3:0] a,
                      input logic [17:0] d, input logic [1:0] m);
    repeat (2) @(posedge sys_clk);
    {rd_sel_n, wr_sel_n, addr} <= {r, w, a};
    {wr_data, byte_write_mask_n} <= {d, m};
    repeat (2) @(posedge sys_clk);
    {k_clk, k_clk_n} <= {~k_clk, ~k_clk_n};
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'b1, 1'b1, addr, ~wr_data, 2'h3);
  endtask
  // command on a k rise, beats from the following k rise
  task automatic wr(input logic [3:0] a, input logic [71:0] d, input logic [7:0] m);
    step(1'b1, 1'b0, a, ~wr_data, 2'h3);
    step(1'b1, 1'b1, a, ~wr_data, 2'h3);
    for (int b = 0; b < 4; b++) step(1'b1, 1'b1, a, d[18*b +: 18], m[2*b +: 2]);
  endtask
  task automatic rd(input logic [3:0] a);
    step(1'b0, 1'b1, a, ~wr_data, 2'h3);
    step(1'b1, 1'b1, a, ~wr_data, 2'h3);
  endtask
endmodule // bqs_ctl_model

// *** tb/test_bqs_port.sv ***
// Purpose: self-checking bench for bqs_port
// Assumes: lane 0 is data bits 8:0, lock count shortened to 8
// Notes:   read beats are gathered on each echo clock rise while the valid flag is high
`timescale 1ns/10ps
module test_bqs_port;
  logic sys_clk, rst_n, k_clk, k_clk_n, rd_sel_n, wr_sel_n, dll_off_n;
  logic [3:0]  addr;              // burst base
  logic [1:0]  mask_n;            // beat mask
  logic [17:0] wr_data, rd_data;  // beat data
  logic        rd_data_oe, eq_t, eq_c, vld, locked;
  logic [17:0] seen[$];           // gathered read beats
  logic        et_q, ec_q;        // previous echo levels
  int          n_errors, total_checks;
  bqs_port #(.LOCK_CYC(8), .KSTAT_CYC(6)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr),
    .byte_write_mask_n(mask_n), .wr_data(wr_data), .dll_off_n(dll_off_n), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .echo_clock_true(eq_t), .echo_clock_comp(eq_c),
    .output_valid_flag(vld), .dll_locked(locked));
  bqs_ctl_model u_ctl (.sys_clk(sys_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .byte_write_mask_n(mask_n),
    .wr_data(wr_data));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // a beat is taken when an echo clock rises while the valid flag stands
  always @(posedge sys_clk) begin
    if (vld === 1'b1 && ((eq_t && !et_q) || (eq_c && !ec_q))) seen.push_back(rd_data);
    et_q <= eq_t;
    ec_q <= eq_c;
  end
  task automatic check(input string name, input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic read_chk(input logic [3:0] a, input logic [71:0] e);
    seen.delete();
    u_ctl.rd(a);
    u_ctl.idle(1);
    check("rd_data_oe", rd_data_oe, 1'b1);
    u_ctl.idle(9);
    check("beat count", seen.size(), 18'h00004);
    for (int b = 0; b < 4; b++) check("rd_data", seen[b], e[18*b +: 18]);
  endtask
  // masked rewrite, then read after a write elsewhere
  task automatic t_mask();
    logic [71:0] od, nd;
    for (int b = 0; b < 4; b++) od[18*b +: 18] = 18'h0A0A0 + 18'(b);
    for (int b = 0; b < 4; b++) nd[18*b +: 18] = 18'h35350 + 18'(b);
    u_ctl.wr(4'h3, od, 8'h00);
    u_ctl.wr(4'h3, nd, {2'h0, 2'h3, 2'h1, 2'h2});
    u_ctl.wr(4'h9, nd, 8'h00);
    read_chk(4'h3, {nd[71:54], od[53:36], nd[35:27], od[26:18], od[17:9], nd[8:0]});
  endtask
  // read straight after a write to the same base
  task automatic t_fwd();
    u_ctl.wr(4'h5, {18'h0C003, 18'h0C002, 18'h0C001, 18'h0C000}, 8'h00);
    read_chk(4'h5, {18'h0C003, 18'h0C002, 18'h0C001, 18'h0C000});
  endtask
  task automatic t_idle();
    u_ctl.idle(4);
    check("rd_data_oe", rd_data_oe, 1'b0);
  endtask
  // loop disable low, then a stopped k
  task automatic t_dll();
    dll_off_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("dll_locked", locked, 1'b0);
    dll_off_n <= 1'b1;
    u_ctl.idle(20);
    check("dll_locked", locked, 1'b1);
    repeat (12) @(posedge sys_clk);
    check("dll_locked", locked, 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end
  initial begin
    {n_errors, total_checks} = 0;
    {rst_n, dll_off_n} = 2'h1;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    u_ctl.idle(20);
    check("dll_locked", locked, 1'b1);
    t_mask();
    t_fwd();
    t_idle();
    t_dll();
    end_sim();
  end
endmodule // test_bqs_port
